// file: hw/gpp_port.sv
// General-purpose pin port: 32 two-way pins plus one output-only flag.
// Control arrives on plain ports as masked group writes of up to 20 pins.
// Pin inputs are treated as asynchronous and synchronised here.
// Notes on behaviour
// - Each pin individually input or output
// - Output pin drives last written level
// - Input level reflects sampled pin state
// - Thirty-two pins plus one output flag
// - Up to twenty pins configured together
// - Per-pin pulldown, individually disabled
// - Per-pin rising or falling edge interrupt
// - Pin output levels last three clocks minimum; the extra flag is not paced
`timescale 1ns/10ps
module gpp_port (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     cfg_we_i,
   input  wire gpp_pkg::gpp_op_t         cfg_op_i,
   input  wire logic [4:0]               cfg_base_i,
   input  wire logic [19:0]              cfg_mask_i,
   input  wire logic [19:0]              cfg_data_i,
   input  wire logic                     extra_flag_we_i,
   input  wire logic                     extra_flag_data_i,
   input  wire logic [31:0]              flag_clear_i,
   input  wire logic [31:0]              general_pin_i,
   output logic      [31:0]              general_pin_o,
   output logic      [31:0]              general_pin_oe_o,
   output logic      [31:0]              pin_pulldown_en_o,
   output logic      [31:0]              pin_level_o,
   output logic      [31:0]              edge_flag_register_o,
   output logic                          irq_o,
   output logic                          extra_flag_output_o,
   output logic                          out_busy_o
);
   logic [31:0] dir;
   logic [31:0] out_req;
   logic [31:0] pull_en;
   logic [31:0] edge_fall;
   logic [31:0] sync1;
   logic [31:0] sync2;
   logic [31:0] level_prev;
   logic [31:0] flags;
   logic [31:0] drive;

   // Next values
   logic [31:0] next_dir;
   logic [31:0] next_out_req;
   logic [31:0] next_pull_en;
   logic [31:0] next_edge_fall;
   logic [31:0] next_flags;
   logic [31:0] next_drive;
   logic [31:0] next_busy;
   logic [31:0] next_pd_out;
   logic        next_irq;
   logic        next_busy_any;
   logic [31:0] edge_hit;
   logic [31:0] grp_mask;
   logic [31:0] grp_data;
   logic        extra;
   logic        next_extra;

   // Output pacing counters, one per pin
   logic [1:0]  hold_cnt [gpp_pkg::PIN_COUNT];
   logic [1:0]  next_hold_cnt [gpp_pkg::PIN_COUNT];

   // Group window shifted to any base so up to 20 pins move at once
   // Bits pushed past pin 31 fall off; there is no wrap-around
   always_comb begin
      grp_mask = 32'({gpp_pkg::ALL_ZERO, cfg_mask_i} << cfg_base_i);
      grp_data = 32'({gpp_pkg::ALL_ZERO, cfg_data_i} << cfg_base_i);
      if (!cfg_we_i) begin
         grp_mask = gpp_pkg::ALL_ZERO;
      end
   end

   // Configuration state
   // One target per strobe; masked-off bits keep their value
   always_comb begin
      next_dir       = dir;
      next_out_req   = out_req;
      next_pull_en   = pull_en;
      next_edge_fall = edge_fall;
      next_extra     = extra;
      case (cfg_op_i)
         gpp_pkg::GPP_OP_DIR: begin
            next_dir = (dir & ~grp_mask) | (grp_data & grp_mask);
         end
         gpp_pkg::GPP_OP_OUT: begin
            next_out_req = (out_req & ~grp_mask) | (grp_data & grp_mask);
         end
         gpp_pkg::GPP_OP_PULL: begin
            next_pull_en = (pull_en & ~grp_mask) | (grp_data & grp_mask);
         end
         gpp_pkg::GPP_OP_EDGE: begin
            next_edge_fall = (edge_fall & ~grp_mask) | (grp_data & grp_mask);
         end
         default: begin
            next_dir = dir;
         end
      endcase
      // Extra flag has no pacing; it follows each write
      if (extra_flag_we_i) begin
         next_extra = extra_flag_data_i;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir       <= gpp_pkg::RST_DIR;
         out_req   <= gpp_pkg::RST_OUT;
         pull_en   <= gpp_pkg::RST_PULL_EN;
         edge_fall <= gpp_pkg::RST_EDGE_FALL;
         extra     <= gpp_pkg::RST_EXTRA_FLAG;
      end else begin
         dir       <= next_dir;
         out_req   <= next_out_req;
         pull_en   <= next_pull_en;
         edge_fall <= next_edge_fall;
         extra     <= next_extra;
      end
   end

   // Per-pin output pacing and edge detection
   genvar gi;
   generate
      for (gi = 0; gi < gpp_pkg::PIN_COUNT; gi++) begin : g_pin
         // A new level is taken only after the old one stood its minimum;
         // later writes coalesce, so the pin shows the last level written.
         always_comb begin
            next_hold_cnt[gi] = hold_cnt[gi];
            next_drive[gi]    = drive[gi];
            if (hold_cnt[gi] != gpp_pkg::HOLD_CNT_ZERO) begin
               next_hold_cnt[gi] = hold_cnt[gi] - gpp_pkg::HOLD_CNT_ONE;
            end else if (out_req[gi] != drive[gi]) begin
               next_drive[gi]    = out_req[gi];
               next_hold_cnt[gi] = gpp_pkg::HOLD_CNT_LOAD;
            end
            next_busy[gi] = (next_hold_cnt[gi] != gpp_pkg::HOLD_CNT_ZERO) || (out_req[gi] != next_drive[gi]);
         end

         // Edge seen on synchronised level, polarity chosen per pin
         // A polarity change alone sets nothing; the level must move
         always_comb begin
            edge_hit[gi] = edge_fall[gi] ? (level_prev[gi] & ~sync2[gi])
                                         : (~level_prev[gi] & sync2[gi]);
            // Set wins over a clear in the same cycle
            next_flags[gi] = edge_hit[gi] | (flags[gi] & ~flag_clear_i[gi]);
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               hold_cnt[gi] <= gpp_pkg::HOLD_CNT_ZERO;
            end else begin
               hold_cnt[gi] <= next_hold_cnt[gi];
            end
         end
      end
   endgenerate

   // Synchroniser: first stage read only by the second
   // Cleared to the pulldown level, so no false edge follows reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= gpp_pkg::ALL_ZERO;
         sync2 <= gpp_pkg::ALL_ZERO;
      end else begin
         sync1 <= general_pin_i;
         sync2 <= sync1;
      end
   end

   // Output-side next values
   always_comb begin
      // Pulldown released while driving, avoids fighting our own output
      next_pd_out   = next_pull_en & ~next_dir;
      next_busy_any = |next_busy;
   end

   // Input-side next values
   always_comb begin
      // Edge detection runs on driven pins too, so outputs read back
      next_irq = |next_flags;
   end

   // Input-side registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_prev           <= gpp_pkg::ALL_ZERO;
         flags                <= gpp_pkg::ALL_ZERO;
         pin_level_o          <= gpp_pkg::ALL_ZERO;
         edge_flag_register_o <= gpp_pkg::ALL_ZERO;
         irq_o                <= 1'h0;
      end else begin
         level_prev           <= sync2;
         flags                <= next_flags;
         pin_level_o          <= sync2;
         edge_flag_register_o <= next_flags;
         irq_o                <= next_irq;
      end
   end

   // Output-side registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive               <= gpp_pkg::RST_OUT;
         general_pin_o       <= gpp_pkg::RST_OUT;
         general_pin_oe_o    <= gpp_pkg::RST_DIR;
         pin_pulldown_en_o   <= gpp_pkg::RST_PULL_EN;
         extra_flag_output_o <= gpp_pkg::RST_EXTRA_FLAG;
         out_busy_o          <= 1'h0;
      end else begin
         drive               <= next_drive;
         general_pin_o       <= next_drive;
         general_pin_oe_o    <= next_dir;
         pin_pulldown_en_o   <= next_pd_out;
         extra_flag_output_o <= next_extra;
         out_busy_o          <= next_busy_any;
      end
   end
endmodule

// file: shared/gpp_pkg.sv
// Constants shared by the general-purpose pin port.
// Assumes a single 100 MHz system clock and no register bus.
package gpp_pkg;
   localparam int          PIN_COUNT       = 32;
   localparam int          GROUP_WIDTH     = 20;
   localparam int          GROUP_SEL_W     = 5;
   localparam int          SYNC_STAGES     = 2;
   localparam real         CLK_PERIOD_NS   = 10.0;
   localparam real         OUT_MIN_LEVEL_NS = 30.0;
   localparam int          OUT_HOLD_CYCLES = int'($ceil(OUT_MIN_LEVEL_NS / CLK_PERIOD_NS));
   localparam logic [1:0]  HOLD_CNT_ONE    = 2'h1;
   localparam logic [1:0]  HOLD_CNT_ZERO   = 2'h0;
   localparam logic [1:0]  HOLD_CNT_LOAD   = 2'(OUT_HOLD_CYCLES - 1);
   localparam logic [31:0] RST_DIR         = 32'h00000000;
   localparam logic [31:0] RST_OUT         = 32'h00000000;
   localparam logic [31:0] RST_PULL_EN     = 32'hFFFFFFFF;
   localparam logic [31:0] RST_EDGE_FALL   = 32'h00000000;
   localparam logic [31:0] ALL_ZERO        = 32'h00000000;
   localparam logic [31:0] ALL_ONE         = 32'hFFFFFFFF;
   localparam logic [19:0] GROUP_ONES      = 20'hFFFFF;
   localparam logic        RST_EXTRA_FLAG  = 1'h0;

   typedef enum logic [1:0] {
      GPP_OP_DIR   = 2'h0,
      GPP_OP_OUT   = 2'h1,
      GPP_OP_PULL  = 2'h2,
      GPP_OP_EDGE  = 2'h3
   } gpp_op_t;
endpackage

// file: verification/gpp_pins.sv
// Outside world of the pins: drivers, pulldowns.
// Enables come from the port and the bench.
`timescale 1ns/10ps
module gpp_pins (
   input  wire logic        clk_i,
   input  wire logic [31:0] general_pin_o,
   input  wire logic [31:0] general_pin_oe_o,
   input  wire logic [31:0] pin_pulldown_en_o,
   input  wire logic [31:0] drive_en_i,
   input  wire logic [31:0] drive_val_i,
   output logic      [31:0] general_pin_i
);
   logic [31:0] last = 32'h0;
   // Floating pins wander so no stale level reads back
   always_ff @(posedge clk_i) last <= general_pin_i;
   assign general_pin_i = general_pin_oe_o & general_pin_o | ~general_pin_oe_o & (drive_en_i & drive_val_i
      | ~drive_en_i & ~pin_pulldown_en_o & ~last);
endmodule

// file: verification/gpp_port_props.sv
// Assertions on the pin port's ports.
// Bound below; one clock, sync reset.
`timescale 1ns/10ps
module gpp_port_props (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             cfg_we_i,
   input wire gpp_pkg::gpp_op_t cfg_op_i,
   input wire logic [4:0]       cfg_base_i,
   input wire logic [19:0]      cfg_mask_i,
   input wire logic [19:0]      cfg_data_i,
   input wire logic [31:0]      general_pin_i,
   input wire logic [31:0]      general_pin_o,
   input wire logic [31:0]      general_pin_oe_o,
   input wire logic [31:0]      pin_pulldown_en_o,
   input wire logic [31:0]      pin_level_o,
   input wire logic [31:0]      edge_flag_register_o,
   input wire logic             irq_o,
   input wire logic             out_busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [1:0] up;
   wire w0 = cfg_we_i && cfg_base_i == 5'h00 && cfg_mask_i[0];
   wire [31:0] lv = pin_level_o;
   // Input pipe holds reset values for three edges
   always_ff @(posedge clk_i) up <= rst_i ? 2'h0 : up + 2'(up != 2'h3);
   dir_wr_a: assert property (w0 && cfg_op_i == gpp_pkg::GPP_OP_DIR
      |=> general_pin_oe_o[0] == $past(cfg_data_i[0])) else $error("dir");
   pull_wr_a: assert property (w0 && cfg_op_i == gpp_pkg::GPP_OP_PULL && !general_pin_oe_o[0]
      |=> pin_pulldown_en_o[0] == $past(cfg_data_i[0])) else $error("pull");
   pull_off_a: assert property ((pin_pulldown_en_o & general_pin_oe_o) == 32'h0)
      else $error("pull on output");
   out_hold_a: assert property ($changed(general_pin_o[0]) |=> $stable(general_pin_o[0]) [*2])
      else $error("short level");
   out_busy_a: assert property ($changed(general_pin_o) |-> out_busy_o) else $error("busy");
   in_sync_a: assert property (up == 2'h3 |-> lv == $past(general_pin_i, 3)) else $error("lag");
   // Flag and level leave the same pipe stage, so they move on the same edge
   flag_edge_a: assert property ($rose(edge_flag_register_o[0]) |-> lv[0] != $past(lv[0]))
      else $error("flag");
   irq_or_a: assert property (irq_o == |edge_flag_register_o) else $error("irq");
   cover property (w0 && cfg_op_i == gpp_pkg::GPP_OP_OUT);
   cover property ($rose(irq_o));
   cover property (out_busy_o ##1 !out_busy_o);
endmodule
bind gpp_port gpp_port_props i_gpp_port_props (
   .clk_i                (clk_i),
   .rst_i                (rst_i),
   .cfg_we_i             (cfg_we_i),
   .cfg_op_i             (cfg_op_i),
   .cfg_base_i           (cfg_base_i),
   .cfg_mask_i           (cfg_mask_i),
   .cfg_data_i           (cfg_data_i),
   .general_pin_i        (general_pin_i),
   .general_pin_o        (general_pin_o),
   .general_pin_oe_o     (general_pin_oe_o),
   .pin_pulldown_en_o    (pin_pulldown_en_o),
   .pin_level_o          (pin_level_o),
   .edge_flag_register_o (edge_flag_register_o),
   .irq_o                (irq_o),
   .out_busy_o           (out_busy_o)
);

// file: verification/tb_gpp_port.sv
// Bench for the pin port against a model.
// Pins come from the gpp_pins model.
`timescale 1ns/10ps
module tb_gpp_port;
   logic clk_i = 0, rst_i = 1, cfg_we_i = 0, extra_flag_we_i = 0, extra_flag_data_i = 0;
   logic irq_o, extra_flag_output_o, out_busy_o;
   gpp_pkg::gpp_op_t cfg_op_i = gpp_pkg::GPP_OP_DIR;
   logic [4:0] cfg_base_i = 5'h0;
   logic [19:0] cfg_mask_i = 20'h0, cfg_data_i = 20'h0;
   logic [31:0] flag_clear_i = '0, drive_en_i = '0, drive_val_i = '0, general_pin_i, general_pin_o;
   logic [31:0] general_pin_oe_o, pin_pulldown_en_o, pin_level_o, edge_flag_register_o, x, e, mo[4];
   int fail_count = 0, compares = 0;
   gpp_port i_gpp_port (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .cfg_we_i             (cfg_we_i),
      .cfg_op_i             (cfg_op_i),
      .cfg_base_i           (cfg_base_i),
      .cfg_mask_i           (cfg_mask_i),
      .cfg_data_i           (cfg_data_i),
      .extra_flag_we_i      (extra_flag_we_i),
      .extra_flag_data_i    (extra_flag_data_i),
      .flag_clear_i         (flag_clear_i),
      .general_pin_i        (general_pin_i),
      .general_pin_o        (general_pin_o),
      .general_pin_oe_o     (general_pin_oe_o),
      .pin_pulldown_en_o    (pin_pulldown_en_o),
      .pin_level_o          (pin_level_o),
      .edge_flag_register_o (edge_flag_register_o),
      .irq_o                (irq_o),
      .extra_flag_output_o  (extra_flag_output_o),
      .out_busy_o           (out_busy_o)
   );
   gpp_pins i_gpp_pins (
      .clk_i             (clk_i),
      .general_pin_o     (general_pin_o),
      .general_pin_oe_o  (general_pin_oe_o),
      .pin_pulldown_en_o (pin_pulldown_en_o),
      .drive_en_i        (drive_en_i),
      .drive_val_i       (drive_val_i),
      .general_pin_i     (general_pin_i)
   );
   initial forever #5 clk_i = ~clk_i;
   task chk(string s, logic [31:0] ex, g);
      compares++;
      if (g !== ex) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", s, ex, g);
      end
   endtask
   task conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task wr(int o, logic [4:0] bs, logic [19:0] mk, dt);
      @(negedge clk_i);
      cfg_we_i = 1;
      cfg_op_i = gpp_pkg::gpp_op_t'(o);
      {cfg_base_i, cfg_mask_i, cfg_data_i} = {bs, mk, dt};
      for (int k = 0; k < 20; k++) if (mk[k] && bs + k < 32) mo[o][bs + k] = dt[k];
      @(negedge clk_i) cfg_we_i = 0;
   endtask
   initial begin
      void'($urandom(26490));
      mo = '{'0, '0, '1, '0};
      repeat (6) @(negedge clk_i);
      rst_i = 0;
      chk("oe", mo[0], general_pin_oe_o);
      chk("pd", mo[2], pin_pulldown_en_o);
      chk("out", mo[1], general_pin_o);
      chk("level", '0, pin_level_o);
      chk("flag", '0, edge_flag_register_o);
      chk("irq", '0, {31'h0, irq_o});
      chk("extra", '0, {31'h0, extra_flag_output_o});
      chk("busy", '0, {31'h0, out_busy_o});
      $display("reset test done");
      wr(2, '0, 20'h1, '0);
      wr(0, '0, 20'h1, 20'h1);
      wr(1, '0, 20'h1, 20'h1);
      wr(1, '0, 20'h1, '0);
      // High level shown one edge after its write must stand three edges
      @(negedge clk_i);
      chk("held", 32'h1, general_pin_o & 32'h1);
      chk("busy", 32'h1, {31'h0, out_busy_o});
      @(negedge clk_i);
      chk("late", '0, general_pin_o & 32'h1);
      repeat (30) begin
         wr($urandom_range(3), 5'($urandom), 20'($urandom), 20'($urandom));
         chk("oe", mo[0], general_pin_oe_o);
         chk("pd", mo[2] & ~mo[0], pin_pulldown_en_o);
      end
      for (int i = 0; i < 20 && out_busy_o !== 1'b0; i++) @(negedge clk_i);
      chk("busy", '0, {31'h0, out_busy_o});
      chk("out", mo[1], general_pin_o);
      $display("config test done");
      wr(0, '0, '1, '0);
      wr(0, 5'h14, '1, '0);
      drive_en_i = '1;
      wr(3, '0, '1, 20'($urandom));
      wr(3, 5'h14, '1, 20'($urandom));
      repeat (6) @(negedge clk_i);
      flag_clear_i = '1;
      repeat (8) begin
         @(negedge clk_i);
         flag_clear_i = '0;
         x = drive_val_i;
         drive_val_i = $urandom;
         e = drive_val_i & ~x & ~mo[3] | ~drive_val_i & x & mo[3];
         repeat (6) @(negedge clk_i);
         chk("level", drive_val_i, pin_level_o);
         chk("flag", e, edge_flag_register_o);
         chk("irq", {31'h0, e != 0}, {31'h0, irq_o});
         flag_clear_i = '1;
      end
      @(negedge clk_i) {extra_flag_we_i, extra_flag_data_i} = 2'h3;
      @(negedge clk_i) extra_flag_we_i = 0;
      chk("extra", 32'h1, {31'h0, extra_flag_output_o});
      @(negedge clk_i) {extra_flag_we_i, extra_flag_data_i} = 2'h2;
      @(negedge clk_i) extra_flag_we_i = 0;
      chk("extra", '0, {31'h0, extra_flag_output_o});
      $display("input test done");
      conclude;
   end
endmodule
